// ---- hw/vram_host_ctl.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Early write: write strobe low before column strobe falls.
// - Late write: write strobe falls after column strobe; used for RMW.
// - New mask: write strobe low at row fall, data pins give mask.
// - Data pins at column fall form per-byte column mask.
// - Unmasked block write keeps both write strobes high at row fall.
// - Fast page: row strobe held low across column cycles.
// - RMW: read, release pins with output gate, drive, write.
module vram_host_ctl
	import vram_ctl_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// User side
	input  wire logic              reqValid,
	output logic                   reqReady,
	input  wire req_t              req,
	output logic                   rdValid,
	output logic      [DATA_W-1:0] rdData,
	output logic                   busy,
	// Device pins, strobes active low
	output logic                   rowStrobe_n,
	output logic                   colStrobe_n,
	output logic                   lowerWriteStrobe_n,
	output logic                   upperWriteStrobe_n,
	output logic                   outputGate_n,
	output logic                   specialFunc,
	output logic      [ROW_W-1:0]  addr,
	input  wire logic [DATA_W-1:0] dqIn,
	output logic      [DATA_W-1:0] dqOut,
	output logic                   dqOe
);

	typedef enum logic [3:0] {
		ST_IDLE, ST_ROW_SETUP, ST_ROW_FALL, ST_COL_SETUP, ST_COL_LOW,
		ST_READ_WAIT, ST_GATE_OFF, ST_LATE_WR, ST_COL_HIGH, ST_PRECHARGE
	} state_t;

	state_t              state;
	req_t                cur;
	logic [TIMER_W-1:0]  timer;
	logic                rowOpen;
	logic [ROW_W-1:0]    openRow;
	logic [DATA_W-1:0]   dqSync;
	logic                timerDone;
	logic                writeKind;
	logic [1:0]          activeBytes;

	// ------------------------------------------------------------
	// Read data synchroniser
	// ------------------------------------------------------------
	pin_sync3 #(
		.WIDTH   (DATA_W)
	) u_dq_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.pinIn   (dqIn),
		.syncOut (dqSync)
	);

	assign timerDone = (timer == '0);
	assign writeKind = (cur.cmd != CMD_READ);
	assign activeBytes = (cur.cmd == CMD_FLASH_WRITE) ? 2'b11 : cur.byteEn;
	// Only offer a page slot to requests the open row can actually serve
	assign reqReady  = (state == ST_IDLE) ||
		(state == ST_COL_HIGH && timerDone && rowOpen && cur.keepRow
		&& req.row == openRow && req.maskSel == cur.maskSel
		&& req.cmd != CMD_MASK_LOAD && req.cmd != CMD_COLOR_LOAD
		&& req.cmd != CMD_FLASH_WRITE);
	assign busy      = (state != ST_IDLE) || rowOpen;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state   <= ST_IDLE;
			cur     <= '0;
			timer   <= '0;
			rowOpen <= 1'b0;
			openRow <= '0;
		end else begin
			if (!timerDone)
				timer <= timer - 1'b1;
			unique case (state)
				ST_IDLE: begin
					if (reqValid) begin
						cur   <= req;
						state <= ST_ROW_SETUP;
						timer <= TIMER_W'(T_SETUP_CYC);
					end
				end
				ST_ROW_SETUP: begin
					if (timerDone) begin
						state <= ST_ROW_FALL;
						timer <= TIMER_W'(T_RCD_CYC);
					end
				end
				ST_ROW_FALL: begin
					if (timerDone) begin
						rowOpen <= 1'b1;
						openRow <= cur.row;
						// Flash needs no column cycle
						if (cur.cmd == CMD_FLASH_WRITE) begin
							state <= ST_COL_HIGH;
							timer <= TIMER_W'(T_CP_CYC);
						end else begin
							state <= ST_COL_SETUP;
							timer <= TIMER_W'(T_SETUP_CYC);
						end
					end
				end
				ST_COL_SETUP: begin
					if (timerDone) begin
						state <= ST_COL_LOW;
						timer <= TIMER_W'(T_CAS_CYC);
					end
				end
				ST_COL_LOW: begin
					if (timerDone) begin
						if (cur.cmd == CMD_READ || cur.cmd == CMD_RMW) begin
							state <= ST_READ_WAIT;
							timer <= TIMER_W'(T_ACC_CYC);
						end else if (cur.cmd == CMD_LATE_WRITE) begin
							state <= ST_LATE_WR;
							timer <= TIMER_W'(T_WP_CYC);
						end else begin
							state <= ST_COL_HIGH;
							timer <= TIMER_W'(T_CP_CYC);
						end
					end
				end
				ST_READ_WAIT: begin
					if (timerDone) begin
						state <= (cur.cmd == CMD_RMW) ? ST_GATE_OFF
							: ST_COL_HIGH;
						timer <= TIMER_W'(T_CP_CYC);
					end
				end
				// gate released in the same cycle new data drives
				ST_GATE_OFF: begin
					if (timerDone) begin
						state <= ST_LATE_WR;
						timer <= TIMER_W'(T_WP_CYC);
					end
				end
				ST_LATE_WR: begin
					if (timerDone) begin
						state <= ST_COL_HIGH;
						timer <= TIMER_W'(T_CP_CYC);
					end
				end
				// reuse the open row for a following column
				ST_COL_HIGH: begin
					if (timerDone) begin
						if (reqValid && cur.keepRow && req.row == openRow
							&& req.maskSel == cur.maskSel
							&& req.cmd != CMD_MASK_LOAD
							&& req.cmd != CMD_COLOR_LOAD
							&& req.cmd != CMD_FLASH_WRITE) begin
							cur   <= req;
							state <= ST_COL_SETUP;
							timer <= TIMER_W'(T_SETUP_CYC);
						end else if (!cur.keepRow || reqValid) begin
							state   <= ST_PRECHARGE;
							rowOpen <= 1'b0;
							timer   <= TIMER_W'(T_RP_CYC);
						end
					end
				end
				ST_PRECHARGE: begin
					if (timerDone)
						state <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rowStrobe_n        <= 1'b1;
			colStrobe_n        <= 1'b1;
			lowerWriteStrobe_n <= 1'b1;
			upperWriteStrobe_n <= 1'b1;
			outputGate_n       <= 1'b1;
			specialFunc        <= 1'b0;
			addr               <= '0;
			dqOut              <= '0;
			dqOe               <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					rowStrobe_n        <= 1'b1;
					colStrobe_n        <= 1'b1;
					lowerWriteStrobe_n <= 1'b1;
					upperWriteStrobe_n <= 1'b1;
					outputGate_n       <= 1'b1;
					dqOe               <= 1'b0;
				end
				ST_ROW_SETUP: begin
					addr <= cur.row;
					// new mask on pins, write strobe low
					// stored mask, pins ignored by device
					// both write strobes high for no mask
					// Mask load told apart from color load by write low
					lowerWriteStrobe_n <= (cur.maskSel == MASK_NONE)
						&& (cur.cmd != CMD_MASK_LOAD);
					upperWriteStrobe_n <= (cur.maskSel == MASK_NONE)
						&& (cur.cmd != CMD_MASK_LOAD);
					specialFunc <= (cur.cmd == CMD_BLOCK_WRITE)
						|| (cur.cmd == CMD_FLASH_WRITE)
						|| (cur.cmd == CMD_MASK_LOAD)
						|| (cur.cmd == CMD_COLOR_LOAD);
					// one bits write, zero bits held
					dqOut <= cur.bitMask;
					dqOe  <= (cur.maskSel == MASK_NEW);
				end
				ST_ROW_FALL: begin
					rowStrobe_n <= 1'b0;
				end
				ST_COL_SETUP: begin
					// low three column bits cleared for block
					addr <= (cur.cmd == CMD_BLOCK_WRITE)
						? {cur.col[COL_W-1:BLOCK_LSBS], BLOCK_LSBS'(0)}
						: cur.col;
					specialFunc <= (cur.cmd == CMD_BLOCK_WRITE);
					// early write strobe set before column fall
					lowerWriteStrobe_n <= !(writeKind
						&& cur.cmd != CMD_LATE_WRITE && cur.cmd != CMD_RMW
						&& activeBytes[0]);
					upperWriteStrobe_n <= !(writeKind
						&& cur.cmd != CMD_LATE_WRITE && cur.cmd != CMD_RMW
						&& activeBytes[1]);
					// gate left high during early write
					outputGate_n <= !(cur.cmd == CMD_READ
						|| cur.cmd == CMD_RMW);
					// pins carry column mask for block write, data for other writes except late write and RMW
					// column mask bit per byte per column
					dqOut <= cur.data;
					dqOe  <= writeKind && cur.cmd != CMD_LATE_WRITE
						&& cur.cmd != CMD_RMW;
				end
				ST_COL_LOW: begin
					// data captured at the later falling edge
					colStrobe_n <= 1'b0;
				end
				ST_READ_WAIT: begin
					dqOe <= 1'b0;
				end
				ST_GATE_OFF: begin
					outputGate_n <= 1'b1;
					dqOut        <= cur.data;
					dqOe         <= 1'b1;
				end
				// write strobe falls with column already low
				ST_LATE_WR: begin
					dqOe               <= 1'b1;
					dqOut              <= cur.data;
					lowerWriteStrobe_n <= !cur.byteEn[0];
					upperWriteStrobe_n <= !cur.byteEn[1];
				end
				// gate keeps read data valid past column rise
				ST_COL_HIGH: begin
					colStrobe_n        <= 1'b1;
					lowerWriteStrobe_n <= 1'b1;
					upperWriteStrobe_n <= 1'b1;
					dqOe               <= 1'b0;
				end
				ST_PRECHARGE: begin
					rowStrobe_n  <= 1'b1;
					outputGate_n <= 1'b1;
					specialFunc  <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read data return
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdValid <= 1'b0;
			rdData  <= '0;
		end else begin
			rdValid <= (state == ST_READ_WAIT) && timerDone;
			if ((state == ST_READ_WAIT) && timerDone)
				rdData <= dqSync;
		end
	end

	// stored mask reuse needs no pin activity
	// masked color goes to enabled columns
	// flash write opens a row with no column cycle data
	// Flash uses the same sequence with the special function pin high

endmodule : vram_host_ctl

// ---- hw/vram_ctl_pkg.sv ----
package vram_ctl_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int DATA_W     = 16;
	localparam int ROW_W      = 9;
	localparam int COL_W      = 9;
	localparam int BLOCK_LSBS = 3;

	// ------------------------------------------------------------
	// Timing, in ns as printed, and cycle counts at 250 MHz
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int T_RP_NS       = 25;
	localparam int T_RCD_NS      = 20;
	localparam int T_CAS_NS      = 15;
	localparam int T_CP_NS       = 10;
	localparam int T_ACC_NS      = 30;
	localparam int T_WP_NS       = 10;
	localparam int T_SETUP_NS    = 5;
	localparam int T_RP_CYC    = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_RCD_CYC   = (T_RCD_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_CAS_CYC   = (T_CAS_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_CP_CYC    = (T_CP_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_ACC_CYC   = (T_ACC_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_WP_CYC    = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int TIMER_W     = 4;

	// ------------------------------------------------------------
	// Commands and mask sources
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_READ, CMD_EARLY_WRITE, CMD_LATE_WRITE, CMD_RMW,
		CMD_BLOCK_WRITE, CMD_FLASH_WRITE, CMD_MASK_LOAD, CMD_COLOR_LOAD
	} cmd_t;

	typedef enum logic [1:0] {
		MASK_NONE, MASK_NEW, MASK_STORED
	} mask_sel_t;

	typedef struct packed {
		cmd_t                cmd;
		mask_sel_t           maskSel;
		logic [1:0]          byteEn;
		logic [ROW_W-1:0]    row;
		logic [COL_W-1:0]    col;
		logic [DATA_W-1:0]   data;
		logic [DATA_W-1:0]   bitMask;
		logic                keepRow;
	} req_t;

	typedef struct packed {
		logic row;
		logic col;
		logic lowWr;
		logic upWr;
		logic gate;
		logic flash;
	} strobes_t;

endpackage : vram_ctl_pkg

// ---- hw/pin_sync3.sv ----
`timescale 1ns/1ps
// Three-stage synchroniser; output changes once stages two and three agree
module pin_sync3
	import vram_ctl_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// ------------------------------------------------------------
	// Capture chain
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Per-bit agreement filter
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					syncOut[i] <= 1'b0;
				end else if (stage2[i] == stage3[i]) begin
					syncOut[i] <= stage3[i];
				end
			end
		end
	endgenerate

endmodule : pin_sync3

// ---- verif/vram_host_ctl_sva.sv ----
`timescale 1ns/1ps
module vram_host_ctl_sva
	import vram_ctl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic busy,
	input wire logic rdValid,
	input wire logic rowStrobe_n,
	input wire logic colStrobe_n,
	input wire logic lowerWriteStrobe_n,
	input wire logic outputGate_n,
	input wire logic dqOe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// Pin sequencing
	// ------------------------------------------------------------
	a_idle_row_closed: assert property (
		!busy |-> rowStrobe_n && colStrobe_n) else $error("row open idle");
	a_col_in_row: assert property (
		!colStrobe_n |-> !rowStrobe_n) else $error("column outside row");
	a_drive_gate_off: assert property (
		dqOe |-> outputGate_n) else $error("pins driven with gate on");
	a_early_data: assert property (
		$fell(colStrobe_n) && !lowerWriteStrobe_n |-> dqOe)
		else $error("early write without data");
	a_late_data: assert property (
		$fell(lowerWriteStrobe_n) && !colStrobe_n |-> dqOe)
		else $error("late write without data");
	a_cas_width: assert property (
		$fell(colStrobe_n) |-> !colStrobe_n[*4]) else $error("column short");
	a_rcd_wait: assert property (
		$fell(rowStrobe_n) |-> colStrobe_n[*5]) else $error("column early");
	a_precharge: assert property (
		$rose(rowStrobe_n) |-> rowStrobe_n[*7]) else $error("precharge short");
	a_rd_pulse: assert property (
		rdValid |=> !rdValid) else $error("read valid too long");
endmodule : vram_host_ctl_sva

// ---- verif/vram_dev_model.sv ----
`timescale 1ns/1ps
module vram_dev_model
	import vram_ctl_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rowStrobe_n,
	input  wire logic              colStrobe_n,
	input  wire logic              lowerWriteStrobe_n,
	input  wire logic              upperWriteStrobe_n,
	input  wire logic              outputGate_n,
	input  wire logic              specialFunc,
	input  wire logic [ROW_W-1:0]  addr,
	input  wire logic [DATA_W-1:0] dq,
	output logic      [DATA_W-1:0] dqDrv
);
	logic [15:0] mem [int];
	logic [15:0] maskReg, colorReg, rowMask, drvData, floatPat;
	logic        maskLoaded, rowSpecial, rowWr, colSeen, drvOe;
	logic [8:0]  rowAddr, colAddr;
	logic [1:0]  wrEn;
	assign wrEn = {!upperWriteStrobe_n, !lowerWriteStrobe_n};
	initial begin
		maskLoaded = 1'b0;
		drvOe = 1'b0;
		floatPat = 16'h5A5A;
	end
	// Released pins show a changing pattern
	always @(posedge ref_clk) floatPat <= ~floatPat;
	assign dqDrv = drvOe ? drvData : floatPat;
	function automatic logic [15:0] get(input int k);
		return mem.exists(k) ? mem[k] : 16'h0000;
	endfunction : get
	task automatic put(input int c, input logic [15:0] d, input logic [1:0] be);
		int k;
		logic [15:0] m;
		k = rowAddr * 512 + c;
		m = rowMask & {{8{be[1]}}, {8{be[0]}}};
		mem[k] = (d & m) | (get(k) & ~m);
	endtask : put
	always @(negedge rowStrobe_n) begin
		rowAddr = addr;
		rowSpecial = specialFunc;
		rowWr = wrEn != 2'b00;
		colSeen = 1'b0;
		rowMask = !rowWr ? 16'hFFFF : maskLoaded ? maskReg : dq;
	end
	always @(negedge colStrobe_n) begin
		colSeen = 1'b1;
		colAddr = addr;
		if (specialFunc)
			for (int i = 0; i < 8; i++)
				put({addr[8:3], 3'(i)}, colorReg, {dq[8+i], dq[i]} & wrEn);
		else if (rowSpecial && rowWr) begin
			maskReg = dq;
			maskLoaded = 1'b1;
		end else if (rowSpecial)
			colorReg = dq;
		else if (wrEn != 2'b00)
			put(int'(addr), dq, wrEn);
	end
	always @(negedge lowerWriteStrobe_n or negedge upperWriteStrobe_n)
		if (!colStrobe_n && !rowStrobe_n && !rowSpecial && !specialFunc)
			put(int'(colAddr), dq, wrEn);
	// flash fills the row on close
	always @(posedge rowStrobe_n)
		if (rowSpecial && !colSeen)
			for (int c = 0; c < 512; c++)
				put(c, colorReg, 2'b11);
	// read drive held past column rise
	always @(negedge colStrobe_n) begin
		#20;
		if (!colStrobe_n && !outputGate_n && wrEn == 2'b00) begin
			drvData = get(rowAddr * 512 + colAddr);
			drvOe = 1'b1;
		end
	end
	// release on gate high, write or row close
	always @(posedge outputGate_n or posedge rowStrobe_n or wrEn) drvOe = 0;
endmodule : vram_dev_model

// ---- verif/tb_vram_host_ctl.sv ----
`timescale 1ns/1ps
module tb_vram_host_ctl
	import vram_ctl_pkg::*;
;
	logic ref_clk, rst_n, reqValid, reqReady, rdValid, busy, dqOe;
	logic rowStrobe_n, colStrobe_n, lowerWriteStrobe_n;
	logic upperWriteStrobe_n, outputGate_n, specialFunc;
	req_t req;
	logic [15:0] rdData, dqIn, dqOut, dqDrv, d;
	logic [8:0] addr;
	int err_total, checks;
	always #2 ref_clk = ~ref_clk;
	assign dqIn = dqOe ? dqOut : dqDrv;
	vram_host_ctl DUT (.ref_clk, .rst_n, .reqValid, .reqReady, .req,
		.rdValid, .rdData, .busy, .rowStrobe_n, .colStrobe_n,
		.lowerWriteStrobe_n, .upperWriteStrobe_n, .outputGate_n,
		.specialFunc, .addr, .dqIn, .dqOut, .dqOe);
	vram_dev_model far (.ref_clk, .rowStrobe_n, .colStrobe_n,
		.lowerWriteStrobe_n, .upperWriteStrobe_n, .outputGate_n,
		.specialFunc, .addr, .dq(dqIn), .dqDrv);
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [15:0] exp, got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic await(ref logic sig, input logic lvl);
		int n;
		n = 0;
		while (sig !== lvl) begin
			@(negedge ref_clk);
			n++;
			if (n > 400) begin
				err_total++;
				tally_and_finish();
			end
		end
	endtask : await
	task automatic issue(input cmd_t c, mask_sel_t m, logic [1:0] be,
		logic [8:0] r, co, logic [15:0] dt, bm, logic k);
		@(posedge ref_clk);
		reqValid <= 1'b1;
		req <= '{c, m, be, r, co, dt, bm, k};
		@(negedge ref_clk);
		await(reqReady, 1'b1);
		@(posedge ref_clk);
		reqValid <= 1'b0;
	endtask : issue
	task automatic look(input logic [8:0] r, co, logic k, logic [15:0] exp);
		issue(CMD_READ, MASK_NONE, 2'b11, r, co, 16'h0000, 16'hFFFF, k);
		await(rdValid, 1'b1);
		chk($sformatf("row %0d col %0d", r, co), exp, rdData);
	endtask : look
	task automatic t_writes;
		issue(CMD_EARLY_WRITE, MASK_NONE, 2'b11, 5, 10, 16'hA5A5, 0, 0);
		issue(CMD_LATE_WRITE, MASK_NONE, 2'b01, 5, 11, 16'h1234, 0, 0);
		issue(CMD_EARLY_WRITE, MASK_NONE, 2'b11, 5, 12, 16'hFFFF, 0, 0);
		issue(CMD_EARLY_WRITE, MASK_NEW, 2'b11, 5, 12, 16'h0000, 16'h00FF, 0);
		look(5, 10, 0, 16'hA5A5);
		look(5, 11, 0, 16'h0034);
		look(5, 12, 0, 16'hFF00);
		issue(CMD_RMW, MASK_NONE, 2'b11, 5, 12, 16'h1234, 0, 0);
		look(5, 12, 0, 16'h1234);
		$display("writes done");
	endtask : t_writes
	task automatic t_page;
		issue(CMD_EARLY_WRITE, MASK_NONE, 2'b11, 5, 14, 16'hC3C3, 0, 1);
		issue(CMD_EARLY_WRITE, MASK_NONE, 2'b11, 5, 15, 16'h3C3C, 0, 0);
		look(5, 14, 1, 16'hC3C3);
		look(5, 15, 0, 16'h3C3C);
		$display("page done");
	endtask : t_page
	task automatic t_block;
		issue(CMD_COLOR_LOAD, MASK_NONE, 2'b11, 6, 0, 16'h5A3C, 0, 0);
		issue(CMD_BLOCK_WRITE, MASK_NONE, 2'b11, 6, 35, 16'h0F05, 0, 0);
		for (int i = 0; i < 8; i++) begin
			d = {i < 4 ? 8'h5A : 8'h00, i % 2 == 0 && i < 4 ? 8'h3C : 8'h00};
			look(6, 9'(32 + i), 0, d);
		end
		$display("block done");
	endtask : t_block
	task automatic t_flash;
		issue(CMD_FLASH_WRITE, MASK_NEW, 2'b01, 7, 0, 0, 16'hFF00, 0);
		look(7, 0, 0, 16'h5A00);
		look(7, 511, 0, 16'h5A00);
		$display("flash done");
	endtask : t_flash
	task automatic t_stored;
		issue(CMD_MASK_LOAD, MASK_NONE, 2'b11, 8, 0, 16'hF0F0, 0, 0);
		issue(CMD_BLOCK_WRITE, MASK_STORED, 2'b11, 9, 0, 16'hFFFF, 0, 0);
		issue(CMD_EARLY_WRITE, MASK_STORED, 2'b11, 9, 16, 16'hFFFF, 0, 0);
		look(9, 0, 0, 16'h5030);
		look(9, 7, 0, 16'h5030);
		look(9, 16, 0, 16'hF0F0);
		$display("stored mask done");
	endtask : t_stored
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		reqValid = 1'b0;
		req = '0;
		err_total = 0;
		checks = 0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_writes();
		t_page();
		t_block();
		t_flash();
		t_stored();
		tally_and_finish();
	end
endmodule : tb_vram_host_ctl
bind vram_host_ctl vram_host_ctl_sva chk (.ref_clk, .rst_n, .busy, .rdValid,
	.rowStrobe_n, .colStrobe_n, .lowerWriteStrobe_n, .outputGate_n, .dqOe);
